/* hdl/vlt_pkg.sv */
package vlt_pkg;

	// table geometry
	localparam int TBL_AW = 12;
	localparam int VLAN_W = 7;
	localparam int LKP_W  = 128;
	localparam logic [11:0] TBL_LAST = 12'hFFF;

	// byte offsets of the register map
	localparam logic [15:0] OFS_VE0      = 16'h0400;
	localparam logic [15:0] OFS_VE2      = 16'h0408;
	localparam logic [15:0] OFS_VIX      = 16'h040C;
	localparam logic [15:0] OFS_VCTL     = 16'h040E;
	localparam logic [15:0] OFS_AK0      = 16'h0410;
	localparam logic [15:0] OFS_AK1      = 16'h0414;
	localparam logic [15:0] OFS_ACTL     = 16'h0418;
	localparam logic [15:0] OFS_ENT1     = 16'h0420;
	localparam logic [15:0] OFS_ENT4_END = 16'h042F;

	// field positions inside the 32-bit word views
	localparam int FOPT_POS    = 27;
	localparam int VIX_IDX_LSB = 16;
	localparam int VIX_GO_POS  = 15;
	localparam int VIX_ACT_LSB = 8;
	localparam int AK0_RSV_POS = 31;
	localparam int AK0_FLT_LSB = 16;
	localparam int ACT_CNT_LSB = 16;
	localparam int ACT_GO_POS  = 7;
	localparam int ACT_RDY_POS = 6;
	localparam int ACT_POL_POS = 5;
	localparam int ACT_RSV_LSB = 3;
	localparam int ACT_DIR_POS = 2;
	localparam int ENT_VLD_POS = 31;

	// values after reset
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [13:0] RST_CNT  = 14'h0000;

	// actions; the all-code is clear for the vlan table, search for lookup
	typedef enum logic [1:0] {
		ACT_NOP = 2'h0,
		ACT_WR  = 2'h1,
		ACT_RD  = 2'h2,
		ACT_ALL = 2'h3
	} vlt_act_t;

	// engine states, one-hot
	typedef enum logic [7:0] {
		ST_INIT  = 8'h01,
		ST_IDLE  = 8'h02,
		ST_VRD   = 8'h04,
		ST_VCLR  = 8'h08,
		ST_ARD   = 8'h10,
		ST_SRD   = 8'h20,
		ST_SCHK  = 8'h40,
		ST_SHOLD = 8'h80
	} vlt_st_t;

	// big-endian byte lane of a word
	function automatic logic [7:0] get_byte(input logic [31:0] w, input logic [1:0] lane);
		case (lane)
			2'h0:    return w[31:24];
			2'h1:    return w[23:16];
			2'h2:    return w[15:8];
			default: return w[7:0];
		endcase
	endfunction

	function automatic logic [31:0] put_byte(input logic [31:0] w, input logic [1:0] lane, input logic [7:0] b);
		logic [31:0] r;
		r = w;
		case (lane)
			2'h0:    r[31:24] = b;
			2'h1:    r[23:16] = b;
			2'h2:    r[15:8] = b;
			default: r[7:0] = b;
		endcase
		return r;
	endfunction

	// fold filter id and mac into a table index
	function automatic logic [11:0] hash_idx(input logic [6:0] flt_id, input logic [47:0] mac);
		logic [59:0] v;
		logic [11:0] h;
		v = {5'h00, flt_id, mac};
		h = 12'h000;
		for (int i = 0; i < 5; i++) begin
			h = h ^ v[12*i +: 12];
		end
		return h;
	endfunction

endpackage

/* hdl/vlt_mem_if.sv */
interface vlt_mem_if #(parameter int W = 8, parameter int AW = 12);
	logic          we;
	logic [AW-1:0] waddr;
	logic [W-1:0]  wdata;
	logic [AW-1:0] raddr_a;
	logic [AW-1:0] raddr_b;
	logic [W-1:0]  rdata_a;
	logic [W-1:0]  rdata_b;

	modport ctl (output we, waddr, wdata, raddr_a, raddr_b, input rdata_a, rdata_b);
	modport mem (input we, waddr, wdata, raddr_a, raddr_b, output rdata_a, rdata_b);
endinterface

/* hdl/vlt_mem.sv */
module vlt_mem
	import vlt_pkg::*;
#(
	parameter int W  = 8,
	parameter int AW = 12
) (
	input wire logic mclk,
	input wire logic nrst,
	vlt_mem_if.mem   mp
);
	typedef struct packed {
		logic [W-1:0] ra;
		logic [W-1:0] rb;
	} vlt_mst_t;

	logic [W-1:0] cells [2**AW];
	vlt_mst_t     q;
	vlt_mst_t     n;

	// two read ports, one cycle latency
	always_comb begin
		n.ra = cells[mp.raddr_a];
		n.rb = cells[mp.raddr_b];
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	// single write port
	always_ff @(posedge mclk) begin
		if (mp.we) begin
			cells[mp.waddr] <= mp.wdata;
		end
	end

	assign mp.rdata_a = q.ra;
	assign mp.rdata_b = q.rb;
endmodule // vlt_mem

/* hdl/vlt_access.sv */
// Contract
// - forward option set: egress only per map
// - map bit 0 is port 1, 1 forwards
// - vlan index selects entry acted upon
// - vlan start bit self-clears when done
// - vlan action: nop, write, read, clear all
// - filter id is folded into the hash
// - mac key split across two key registers
// - direct mode indexes by low mac bits
// - control bit 2 picks direct or hashed
// - lookup action: nop, write, read, search
// - lookup start bit self-clears when done
// - valid entry count reported after search
// - ready flag set per entry, cleared on read of the last entry byte
// - poll flag is ready or search ended
// - entry data via four shared registers
// - entry word 0 bit 27 is forward option
module vlt_access
	import vlt_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        nrst,
	input  wire logic [15:0] reg_addr,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	input  wire logic        fwd_req,
	input  wire logic [11:0] fwd_vid,
	input  wire logic [5:0]  fwd_other_map,
	output logic             fwd_valid,
	output logic      [5:0]  fwd_map
);
	localparam logic [13:0] ENT_W = OFS_ENT1[15:2];
	typedef struct packed {
		vlt_st_t        st;
		logic [11:0]    ptr;
		logic           fopt;
		logic [5:0]     fmap;
		logic [11:0]    vidx;
		logic           vgo;
		vlt_act_t       vact;
		logic           k31;
		logic [6:0]     flt_id;
		logic [15:0]    mac_hi;
		logic [31:0]    mac_lo;
		logic [1:0]     k43;
		logic           adir;
		vlt_act_t       aact;
		logic           ago;
		logic           ardy;
		logic           aend;
		logic [13:0]    vcnt;
		logic [3:0][31:0] ent;
		logic [7:0]     rdata;
		logic           fpend;
		logic [5:0]     foth;
		logic           fvalid;
		logic [5:0]     fout;
	} vlt_state_t;
	vlt_state_t  q;
	vlt_state_t  n;
	logic [11:0] aidx;
	logic [31:0] w;
	logic [13:0] widx;
	logic [1:0]  lane;
	vlt_mem_if #(.W(VLAN_W), .AW(TBL_AW)) vm ();
	vlt_mem_if #(.W(LKP_W), .AW(TBL_AW))  am ();
	vlt_mem #(.W(VLAN_W), .AW(TBL_AW)) u_vmem (
		.mclk (mclk),
		.nrst (nrst),
		.mp   (vm.mem)
	);
	vlt_mem #(.W(LKP_W), .AW(TBL_AW)) u_amem (
		.mclk (mclk),
		.nrst (nrst),
		.mp   (am.mem)
	);
	// word view of the register map
	function automatic logic [31:0] reg_word(input vlt_state_t s, input logic [13:0] wi);
		logic [31:0] r;
		r = RST_WORD;
		case (wi)
			OFS_VE0[15:2]:  r[FOPT_POS] = s.fopt;
			OFS_VE2[15:2]:  r[5:0] = s.fmap;
			OFS_VIX[15:2]:  r = {4'h0, s.vidx, s.vgo, 5'h00, s.vact, 8'h00};
			OFS_AK0[15:2]:  r = {s.k31, 8'h00, s.flt_id, s.mac_hi};
			OFS_AK1[15:2]:  r = s.mac_lo;
			OFS_ACTL[15:2]: r = {2'h0, s.vcnt, 8'h00, s.ago, s.ardy, s.ardy | s.aend, s.k43, s.adir, s.aact};
			default: begin
				if (wi >= ENT_W && wi < ENT_W + 14'h0004) begin
					r = s.ent[2'(wi - ENT_W)];
				end
			end
		endcase
		return r;
	endfunction
	// lookup index, hashed or direct
	assign aidx = q.adir ? q.mac_lo[11:0] : hash_idx(q.flt_id, {q.mac_hi, q.mac_lo});
	assign lane = reg_addr[1:0];
	assign widx = reg_addr[15:2];
	assign w    = put_byte(reg_word(q, widx), lane, reg_wdata);
	// next state: read effects, then engine, then register writes
	always_comb begin
		n = q;
		vm.we      = 1'b0;
		vm.waddr   = q.vidx;
		vm.wdata   = {q.fopt, q.fmap};
		vm.raddr_a = q.vidx;
		vm.raddr_b = fwd_vid;
		am.we      = 1'b0;
		am.waddr   = aidx;
		am.wdata   = q.ent;
		am.raddr_a = aidx;
		am.raddr_b = q.ptr;

		// register read and its side effect
		if (reg_rd) begin
			n.rdata = get_byte(reg_word(q, widx), lane);
			if (reg_addr == OFS_ENT4_END) begin
				n.ardy = 1'b0;
			end
		end

		// table access engine
		case (q.st)
			ST_INIT: begin
				vm.we    = 1'b1;
				vm.waddr = q.ptr;
				vm.wdata = '0;
				am.we    = 1'b1;
				am.waddr = q.ptr;
				am.wdata = '0;
				n.ptr    = q.ptr + 12'h001;
				if (q.ptr == TBL_LAST) begin
					n.st = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (q.vgo) begin
					case (q.vact)
						ACT_WR: begin
							vm.we = 1'b1;
							n.vgo = 1'b0;
						end
						ACT_RD:  n.st = ST_VRD;
						ACT_ALL: begin
							n.ptr = 12'h000;
							n.st  = ST_VCLR;
						end
						default: n.vgo = 1'b0;
					endcase
				end else if (q.ago) begin
					n.aend = 1'b0;
					case (q.aact)
						ACT_WR: begin
							am.we = 1'b1;
							n.ago = 1'b0;
						end
						ACT_RD:  n.st = ST_ARD;
						ACT_ALL: begin
							n.ptr  = 12'h000;
							n.vcnt = RST_CNT;
							n.st   = ST_SRD;
						end
						default: n.ago = 1'b0;
					endcase
				end
			end
			ST_VRD: begin
				n.fopt = vm.rdata_a[6];
				n.fmap = vm.rdata_a[5:0];
				n.vgo  = 1'b0;
				n.st   = ST_IDLE;
			end
			ST_VCLR: begin
				vm.we    = 1'b1;
				vm.waddr = q.ptr;
				vm.wdata = '0;
				n.ptr    = q.ptr + 12'h001;
				if (q.ptr == TBL_LAST) begin
					n.vgo = 1'b0;
					n.st  = ST_IDLE;
				end
			end
			ST_ARD: begin
				n.ent = am.rdata_a;
				n.ago = 1'b0;
				n.st  = ST_IDLE;
			end
			ST_SRD: n.st = ST_SCHK;
			ST_SCHK: begin
				if (am.rdata_b[ENT_VLD_POS]) begin
					n.ent  = am.rdata_b;
					n.ardy = 1'b1;
					n.vcnt = q.vcnt + 14'h0001;
					n.st   = ST_SHOLD;
				end else if (q.ptr == TBL_LAST) begin
					n.ago  = 1'b0;
					n.aend = 1'b1;
					n.st   = ST_IDLE;
				end else begin
					n.ptr = q.ptr + 12'h001;
					n.st  = ST_SRD;
				end
			end
			ST_SHOLD: begin
				// waits for software to drain the entry
				if (!q.ardy) begin
					if (q.ptr == TBL_LAST) begin
						n.ago  = 1'b0;
						n.aend = 1'b1;
						n.st   = ST_IDLE;
					end else begin
						n.ptr = q.ptr + 12'h001;
						n.st  = ST_SRD;
					end
				end
			end
			default: n.st = ST_IDLE;
		endcase

		// register writes; a start write beats the engine's clear
		if (reg_wr) begin
			case (widx)
				OFS_VE0[15:2]: n.fopt = w[FOPT_POS];
				OFS_VE2[15:2]: n.fmap = w[5:0];
				OFS_VIX[15:2]: begin
					n.vidx = w[VIX_IDX_LSB +: 12];
					n.vact = vlt_act_t'(w[VIX_ACT_LSB +: 2]);
					if (lane == OFS_VCTL[1:0] && reg_wdata[7]) begin
						n.vgo = 1'b1;
					end
				end
				OFS_AK0[15:2]: begin
					n.k31    = w[AK0_RSV_POS];
					n.flt_id = w[AK0_FLT_LSB +: 7];
					n.mac_hi = w[15:0];
				end
				OFS_AK1[15:2]: n.mac_lo = w;
				OFS_ACTL[15:2]: begin
					n.aact = vlt_act_t'(w[1:0]);
					n.adir = w[ACT_DIR_POS];
					n.k43  = w[ACT_RSV_LSB +: 2];
					if (lane == 2'h3 && reg_wdata[ACT_GO_POS]) begin
						n.ago = 1'b1;
					end
				end
				default: begin
					if (widx >= ENT_W && widx < ENT_W + 14'h0004) begin
						n.ent[2'(widx - ENT_W)] = w;
					end
				end
			endcase
		end

		// vlan forwarding decision, map bit i is port i+1
		n.fpend  = fwd_req;
		n.foth   = fwd_other_map;
		n.fvalid = q.fpend;
		if (q.fpend) begin
			n.fout = vm.rdata_b[6] ? vm.rdata_b[5:0] : q.foth;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			q      <= '0;
			q.st   <= ST_INIT;
			q.vact <= ACT_NOP;
			q.aact <= ACT_NOP;
		end else begin
			q <= n;
		end
	end

	assign reg_rdata = q.rdata;
	assign fwd_valid = q.fvalid;
	assign fwd_map   = q.fout;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);
	sequence s_fwd_ask;
		fwd_req ##1 1'b1;
	endsequence
	property p_fwd_map;
		s_fwd_ask |=> fwd_valid && fwd_map == ($past(vm.rdata_b[6]) ? $past(vm.rdata_b[5:0]) : $past(fwd_other_map, 2));
	endproperty
	a_fwd_map: assert property (p_fwd_map) else $error("forward map mismatch");
	property p_vnop;
		q.st == ST_IDLE && q.vgo && q.vact == ACT_NOP && !reg_wr |=> !q.vgo;
	endproperty
	a_vnop: assert property (p_vnop) else $error("vlan nop left start set");
	property p_vwrite;
		q.st == ST_IDLE && q.vgo && q.vact == ACT_WR |-> vm.we && vm.waddr == q.vidx ##1 !q.vgo || $past(reg_wr);
	endproperty
	a_vwrite: assert property (p_vwrite) else $error("vlan write wrong");
	property p_vclear;
		q.st == ST_VCLR |-> vm.we && vm.wdata == '0 && vm.waddr == q.ptr;
	endproperty
	a_vclear: assert property (p_vclear) else $error("vlan clear not zero");
	sequence s_vread;
		q.st == ST_IDLE && q.vgo && q.vact == ACT_RD ##1 q.st == ST_VRD;
	endsequence
	property p_vread;
		s_vread |=> q.fmap == $past(vm.rdata_a[5:0]) && q.fopt == $past(vm.rdata_a[6]) && !q.vgo;
	endproperty
	a_vread: assert property (p_vread) else $error("vlan read not loaded");
	property p_direct;
		q.adir && am.we && q.st == ST_IDLE |-> am.waddr == q.mac_lo[11:0];
	endproperty
	a_direct: assert property (p_direct) else $error("direct index wrong");
	property p_hashed;
		!q.adir && am.we && q.st == ST_IDLE |-> am.waddr == hash_idx(q.flt_id, {q.mac_hi, q.mac_lo});
	endproperty
	a_hashed: assert property (p_hashed) else $error("hashed index wrong");
	property p_rdy_clear;
		q.st == ST_SHOLD && reg_rd && reg_addr == OFS_ENT4_END |=> !q.ardy;
	endproperty
	a_rdy_clear: assert property (p_rdy_clear) else $error("ready not cleared");
	property p_found;
		q.st == ST_SCHK && am.rdata_b[ENT_VLD_POS] |=> q.ardy && q.vcnt == $past(q.vcnt) + 14'h0001 && q.ent == $past(am.rdata_b);
	endproperty
	a_found: assert property (p_found) else $error("found entry not presented");
	property p_poll;
		reg_rd && reg_addr == OFS_ACTL + 16'h0003 |=> reg_rdata[ACT_POL_POS] == ($past(q.ardy) | $past(q.aend));
	endproperty
	a_poll: assert property (p_poll) else $error("poll flag wrong");
	property p_srch_end;
		q.st == ST_SCHK && !am.rdata_b[ENT_VLD_POS] && q.ptr == TBL_LAST && !reg_wr |=> !q.ago && q.aend;
	endproperty
	a_srch_end: assert property (p_srch_end) else $error("search end not flagged");
endmodule // vlt_access

/* bench/vlan_and_lookup_table_access_tb.sv */
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin error_cnt++; $display("unexpected t=%0t got %h exp %h", $time, got, exp); end end

module vlan_and_lookup_table_access_tb
	import vlt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic        mclk;
	logic        nrst;
	logic [15:0] reg_addr;
	logic        reg_wr;
	logic        reg_rd;
	logic [7:0]  reg_wdata;
	logic [7:0]  reg_rdata;
	logic        fwd_req;
	logic [11:0] fwd_vid;
	logic [5:0]  fwd_other_map;
	logic        fwd_valid;
	logic [5:0]  fwd_map;
	logic [7:0]  rb;
	logic [7:0]  exp_q [2];
	int          error_cnt = 0;
	int          n_compared = 0;
	int          cyc_cnt = 0;

	vlt_access dut (
		.mclk          (mclk),
		.nrst          (nrst),
		.reg_addr      (reg_addr),
		.reg_wr        (reg_wr),
		.reg_rd        (reg_rd),
		.reg_wdata     (reg_wdata),
		.reg_rdata     (reg_rdata),
		.fwd_req       (fwd_req),
		.fwd_vid       (fwd_vid),
		.fwd_other_map (fwd_other_map),
		.fwd_valid     (fwd_valid),
		.fwd_map       (fwd_map)
	);

	// 20 MHz clock
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	// ceiling: init, one clear and one search, each ~4096..8192 cycles, plus polling
	always @(posedge mclk) begin
		cyc_cnt++;
		if (cyc_cnt == 40000) begin
			error_cnt++;
			$display("unexpected t=%0t run did not complete", $time);
			finish_test();
		end
	end

	// one-cycle write pulse
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge mclk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge mclk);
		reg_wr = 1'b0;
	endtask

	// one-cycle read pulse, data taken once it has settled
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(negedge mclk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge mclk);
		reg_rd = 1'b0;
		@(negedge mclk);
		d = reg_rdata;
	endtask

	task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
		rd(a, rb);
		`CHK(rb, exp)
	endtask

	// poll until the start bit of a control byte drops
	task automatic wait_done(input logic [15:0] a);
		for (int i = 0; i < 3000; i++) begin
			rd(a, rb);
			if (rb[7] === 1'b0) break;
		end
	endtask

	// poll until an entry is ready or the search is over
	task automatic wait_rdy();
		for (int i = 0; i < 4000; i++) begin
			rd(OFS_ACTL + 16'h3, rb);
			if (rb[6] === 1'b1 || rb[7] === 1'b0) break;
		end
	endtask

	// forwarding request, answer expected exactly two edges later
	task automatic fwd_chk(input logic [11:0] vid, input logic [5:0] other, input logic [5:0] exp);
		@(negedge mclk);
		fwd_req = 1'b1;
		fwd_vid = vid;
		fwd_other_map = other;
		@(negedge mclk);
		fwd_req = 1'b0;
		`CHK(fwd_valid, 1'b0)
		@(negedge mclk);
		`CHK(fwd_valid, 1'b1)
		`CHK(fwd_map, exp)
	endtask

	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		nrst = 1'b0;
		reg_addr = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'h00;
		fwd_req = 1'b0;
		fwd_vid = 12'h000;
		fwd_other_map = 6'h00;
		repeat (20) @(negedge mclk);
		nrst = 1'b1;
		rd_chk(OFS_ACTL + 16'h3, 8'h00);
		rd_chk(OFS_ACTL + 16'h1, 8'h00);
		rd_chk(OFS_VCTL, 8'h00);
		repeat (4100) @(negedge mclk);
		// read-only bits, unmapped place
		wr(OFS_VE2, 8'hFF);
		rd_chk(OFS_VE2, 8'h00);
		wr(OFS_VIX, 8'hFA);
		rd_chk(OFS_VIX, 8'h0A);
		wr(16'h0500, 8'h5A);
		rd_chk(16'h0500, 8'h00);
		// vlan write with forward option at index 0xABC
		wr(OFS_VIX + 16'h1, 8'hBC);
		wr(OFS_VE2 + 16'h3, 8'h2A);
		wr(OFS_VE0, 8'h08);
		wr(OFS_VCTL, 8'h81);
		wait_done(OFS_VCTL);
		rd_chk(OFS_VCTL, 8'h01);
		fwd_chk(12'hABC, 6'h15, 6'h2A);
		fwd_chk(12'hABD, 6'h15, 6'h15);
		// read back after scrubbing the staging bytes
		wr(OFS_VE2 + 16'h3, 8'h00);
		wr(OFS_VE0, 8'h00);
		wr(OFS_VCTL, 8'h82);
		wait_done(OFS_VCTL);
		rd_chk(OFS_VE2 + 16'h3, 8'h2A);
		rd_chk(OFS_VE0, 8'h08);
		// no operation, then clear of the whole table
		wr(OFS_VCTL, 8'h80);
		wait_done(OFS_VCTL);
		rd_chk(OFS_VCTL, 8'h00);
		wr(OFS_VCTL, 8'h83);
		wait_done(OFS_VCTL);
		fwd_chk(12'hABC, 6'h15, 6'h15);
		// hashed write: fid 05, mac 1000_0000_0456 folds to 0x553
		wr(OFS_AK0 + 16'h1, 8'h05);
		wr(OFS_AK0 + 16'h2, 8'h10);
		wr(OFS_AK1 + 16'h2, 8'h04);
		wr(OFS_AK1 + 16'h3, 8'h56);
		wr(OFS_ENT1, 8'h80);
		wr(OFS_ENT4_END, 8'h5A);
		wr(OFS_ACTL + 16'h3, 8'h81);
		wait_done(OFS_ACTL + 16'h3);
		rd_chk(OFS_ACTL + 16'h3, 8'h01);
		// direct read of slot 0x553, upper key bits must not matter
		wr(OFS_ENT4_END, 8'h00);
		wr(OFS_AK1, 8'h77);
		wr(OFS_AK1 + 16'h2, 8'h05);
		wr(OFS_AK1 + 16'h3, 8'h53);
		wr(OFS_ACTL + 16'h3, 8'h86);
		wait_done(OFS_ACTL + 16'h3);
		rd_chk(OFS_ENT4_END, 8'h5A);
		// second entry straight into slot 0x123
		wr(OFS_AK1 + 16'h2, 8'h01);
		wr(OFS_AK1 + 16'h3, 8'h23);
		wr(OFS_ENT4_END, 8'hA5);
		wr(OFS_ACTL + 16'h3, 8'h85);
		wait_done(OFS_ACTL + 16'h3);
		// search returns both in address order
		exp_q[0] = 8'hA5;
		exp_q[1] = 8'h5A;
		wr(OFS_ACTL + 16'h3, 8'h83);
		for (int k = 0; k < 2; k++) begin
			wait_rdy();
			rd_chk(OFS_ACTL + 16'h3, 8'hE3);
			rd_chk(OFS_ENT4_END, exp_q[k]);
		end
		wait_done(OFS_ACTL + 16'h3);
		rd_chk(OFS_ACTL + 16'h3, 8'h23);
		rd_chk(OFS_ACTL + 16'h1, 8'h02);
		rd_chk(OFS_ACTL, 8'h00);
		finish_test();
	end

endmodule // vlan_and_lookup_table_access_tb
